// ===== shared/clk_ctrl_pkg.sv
// Constants, register map and types shared by the clock controller files.
// Assumes a 32-bit APB slave on pclk and oscillator/PLL events sampled on pclk.
package clk_ctrl_pkg;
   // Register byte offsets.
   localparam logic [11:0] off_divider   = 12'h000;
   localparam logic [11:0] off_control   = 12'h004;
   localparam logic [11:0] off_status    = 12'h008;
   localparam logic [11:0] off_freq_meas = 12'h00c;
   // Divider field positions and widths.
   localparam int ref_div_lsb  = 0;
   localparam int ref_div_w    = 4;
   localparam int mult_lsb     = 8;
   localparam int mult_w       = 6;
   // Control bit positions.
   localparam int ctl_auto      = 0;
   localparam int ctl_acq       = 1;
   localparam int ctl_pll_on    = 2;
   localparam int ctl_pll_sel   = 3;
   localparam int ctl_lock_ie   = 4;
   localparam int ctl_cm_en     = 5;
   localparam int ctl_scm_en    = 6;
   // Status bit positions.
   localparam int st_lock       = 0;
   localparam int st_track      = 1;
   localparam int st_lock_irq   = 2;
   localparam int st_scm        = 3;
   localparam int st_check_busy = 4;
   localparam int st_osc_ok     = 5;
   localparam int st_ext_clk    = 6;
   localparam int st_switching  = 7;
   localparam int st_cm_fail    = 8;
   // Reset values.
   localparam logic [31:0] divider_reset = 32'h0000_0000;
   localparam logic [6:0]  control_reset = 7'h63;
   // Clock switch: 4 oscillator plus 4 PLL cycles.
   localparam int          switch_osc_cycles = 4;
   localparam int          switch_pll_cycles = 4;
   localparam logic [3:0]  switch_len = 4'(switch_osc_cycles + switch_pll_cycles);
   // Quality check window and threshold.
   localparam int          check_window_vco = 50000;
   localparam logic [12:0] osc_ok_edges     = 13'h1000;
   // Clock monitor RC delay in nanoseconds and its pclk count (longest time, rounded down).
   localparam int          cm_delay_ns     = 1000;
   localparam int          clk_period_ns   = 10;
   localparam logic [7:0]  cm_delay_cycles = 8'(cm_delay_ns / clk_period_ns);

   typedef enum logic [1:0]
   {
      sw_idle    = 2'b00,
      sw_freeze  = 2'b01,
      sw_swap    = 2'b11
   } switch_state_t;
endpackage

// ===== shared/clk_div_if.sv
// Bundle between the controller top and its clock-event helpers.
// Assumes all signals are pclk-domain single-cycle strobes or levels.
interface clk_div_if;
   logic       osc_edge;
   logic       vco_edge;
   logic [3:0] ref_div;
   logic [5:0] mult;
   logic       ref_tick;
   logic       fb_tick;
   logic       check_start;
   logic       check_busy;
   logic       osc_ok;
   logic       check_fail;
   modport ctrl (output osc_edge, vco_edge, ref_div, mult, check_start,
                 input ref_tick, fb_tick, check_busy, osc_ok, check_fail);
   modport divs (input osc_edge, vco_edge, ref_div, mult, output ref_tick, fb_tick);
   modport qual (input osc_edge, vco_edge, check_start,
                 output check_busy, osc_ok, check_fail);
endinterface

// ===== core/pll_dividers.sv
// Reference and feedback dividers, clocked by pclk and fed edge strobes.
// Assumes oscillator and VCO edges arrive already synchronised.
module pll_dividers
(
   // Clock and reset
   input  wire logic  pclk,
   input  wire logic  presetn,
   // Divider bundle
   clk_div_if.divs    d
);
   typedef struct packed
   {
      logic [3:0] ref_cnt;
      logic [6:0] fb_cnt;
      logic       ref_tick;
      logic       fb_tick;
   } div_state_t;

   div_state_t s_q;
   div_state_t s_d;
   logic [6:0] fb_last;

   always_comb
   begin
      s_d = s_q;
      s_d.ref_tick = 1'b0;
      s_d.fb_tick = 1'b0;
      fb_last = {d.mult, 1'b1};
      if (d.osc_edge)
      begin
         if (s_q.ref_cnt >= d.ref_div) // see RL1
         begin
            s_d.ref_cnt = 4'h0;
            s_d.ref_tick = 1'b1;
         end
         else
            s_d.ref_cnt = s_q.ref_cnt + 4'h1;
      end
      if (d.vco_edge)
      begin
         if (s_q.fb_cnt >= fb_last) // see RL2
         begin
            s_d.fb_cnt = 7'h00;
            s_d.fb_tick = 1'b1;
         end
         else
            s_d.fb_cnt = s_q.fb_cnt + 7'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign d.ref_tick = s_q.ref_tick;
   assign d.fb_tick = s_q.fb_tick;
endmodule

// ===== core/clock_quality_checker.sv
// Counts oscillator edges inside a window of minimum-frequency VCO cycles.
// Assumes edge strobes are synchronised pclk pulses.
module clock_quality_checker
#(
   parameter int unsigned window_cycles = 50000
)
(
   // Clock and reset
   input  wire logic  pclk,
   input  wire logic  presetn,
   // Checker bundle
   clk_div_if.qual    q
);
   typedef struct packed
   {
      logic        busy;
      logic        ok;
      logic        fail;
      logic [15:0] vco_cnt;
      logic [12:0] osc_cnt;
   } chk_state_t;

   chk_state_t s_q;
   chk_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.fail = 1'b0;
      if (q.check_start)
      begin
         s_d = '0;
         s_d.busy = 1'b1; // see RL20
      end
      else if (s_q.busy)
      begin
         if (q.osc_edge && s_q.osc_cnt != clk_ctrl_pkg::osc_ok_edges)
            s_d.osc_cnt = s_q.osc_cnt + 13'h0001; // see RL21
         if (q.vco_edge)
         begin
            if (s_q.vco_cnt == 16'(window_cycles - 1))
            begin
               if (s_d.osc_cnt >= clk_ctrl_pkg::osc_ok_edges) // see RL21
               begin
                  s_d.busy = 1'b0;
                  s_d.ok = 1'b1;
               end
               else
                  s_d.fail = 1'b1; // Window restarts; see RL25
               s_d.vco_cnt = 16'h0000;
               s_d.osc_cnt = 13'h0000;
            end
            else
               s_d.vco_cnt = s_q.vco_cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign q.check_busy = s_q.busy;
   assign q.osc_ok = s_q.ok;
   assign q.check_fail = s_q.fail;
endmodule

// ===== core/clock_controller.sv
// Digital control of a PLL clock generator with an APB register file.
// Assumes oscillator, VCO and pin signals are asynchronous and synchronised here.
// Notes on behaviour
// RL1 - Reference divides oscillator by setting plus one
// RL2 - Feedback divides by twice multiplier plus two
// RL3 - Acquisition mode keeps tracking flag clear
// RL4 - Nearly correct frequency sets tracking
// RL5 - Automatic mode lets detector choose filter
// RL6 - Tracking flag uses two tolerance hysteresis
// RL7 - Lock flag uses two tolerance hysteresis
// RL8 - Lock change raises interrupt when enabled
// RL9 - Manual mode: acquisition bit selects filter
// RL10 - Software sets acquisition before powering PLL
// RL11 - Software waits acquisition and settling times
// RL12 - Software selects PLL only while locked
// RL13 - Select bit drives system clock from PLL
// RL14 - Power-off ignored while PLL selected
// RL15 - Switch freezes clocks, eight cycles maximum
// RL16 - Self clock mode substitutes minimum PLL
// RL17 - Bus clock pin follows bus clock
// RL18 - External select pin latched leaving reset
// RL19 - Monitor timeout flags failure, self-clock or reset
// RL20 - Check starts on reset, wake, failure
// RL21 - Count 4096 edges in 50000 cycles
// RL22 - Keep PLL, regulator on during check
// RL23 - Self clock entry clears PLL select
// RL24 - Good oscillator leaves self clock mode
// RL25 - Failed window restarts the check
module clock_controller
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Asynchronous clock observations and pins
   input  wire logic        oscillator_clock,
   input  wire logic        pll_output_clock,
   input  wire logic        external_clock_select_pin,
   input  wire logic        lock_in_window,
   input  wire logic        lock_out_window,
   input  wire logic        track_in_window,
   input  wire logic        track_out_window,
   input  wire logic        full_stop_wake,
   // Clock tree control
   output logic             main_system_clock_from_pll,
   output logic             clocks_frozen,
   output logic             self_clock_mode,
   output logic             external_clock_mode,
   output logic             filter_acquisition,
   output logic             pll_enable,
   output logic             voltage_regulator_enable,
   output logic             bus_clock_output_pin,
   output logic             lock_irq,
   output logic             clock_monitor_reset,
   output logic [3:0]       ref_tick_count,
   output logic             ref_clock_tick,
   output logic             fb_clock_tick
);
   localparam int nsync = 8;

   typedef struct packed
   {
      logic [nsync-1:0]            s1;
      logic [nsync-1:0]            s2;
      logic [nsync-1:0]            s3;
      logic [3:0]                  ref_div;
      logic [5:0]                  mult;
      logic [6:0]                  ctl;
      logic                        lock;
      logic                        track;
      logic                        lock_irq;
      logic                        scm;
      logic                        cm_fail;
      logic                        cm_reset;
      logic                        cm_event;
      logic                        ext_mode;
      logic [2:0]                  rst_seen;
      logic                        sel_active;
      clk_ctrl_pkg::switch_state_t sw;
      logic [3:0]                  sw_cnt;
      logic [7:0]                  cm_cnt;
      logic                        bus_div;
      logic [3:0]                  ref_ticks;
      logic [31:0]                 rdata;
   } ctl_state_t;

   ctl_state_t s_q;
   ctl_state_t s_d;
   clk_div_if  bus ();

   logic [nsync-1:0] raw_in;
   logic [nsync-1:0] rise;
   logic             wr;
   logic             rd;
   logic             auto_mode;
   logic             filter_acq;
   logic             lock_next;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a[11:2] == off[11:2]);
   endfunction

   assign raw_in = {full_stop_wake, track_out_window, track_in_window, lock_out_window,
                    lock_in_window, external_clock_select_pin, pll_output_clock,
                    oscillator_clock};
   // Edges are taken between the second and third stage only.
   assign rise = s_q.s2 & ~s_q.s3;
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign auto_mode = s_q.ctl[clk_ctrl_pkg::ctl_auto];

   assign bus.osc_edge = rise[0];
   assign bus.vco_edge = rise[1];
   assign bus.ref_div = s_q.ref_div;
   assign bus.mult = s_q.mult;
   assign bus.check_start = (rise[7] && !s_q.scm) || s_q.cm_event
                            || (!s_q.rst_seen[0]);

   pll_dividers u_div
   (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (bus)
   );

   clock_quality_checker #(.window_cycles(clk_ctrl_pkg::check_window_vco)) u_chk
   (
      .pclk    (pclk),
      .presetn (presetn),
      .q       (bus)
   );

   always_comb
   begin
      s_d = s_q;
      s_d.s1 = raw_in;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      s_d.rst_seen = {s_q.rst_seen[1:0], 1'b1};
      s_d.cm_reset = 1'b0;
      s_d.cm_event = 1'b0;
      filter_acq = 1'b1;
      lock_next = s_q.lock;
      // The synchronised pin is valid from the third edge after release.
      if (s_q.rst_seen == 3'b011)
         s_d.ext_mode = s_q.s2[2]; // see RL18
      // Lock hysteresis: set inside lock tolerance, clear outside unlock tolerance.
      if (rise[3] || s_q.s2[3])
         lock_next = 1'b1; // see RL7
      else if (s_q.s2[4])
         lock_next = 1'b0; // see RL7
      s_d.lock = lock_next;
      if (auto_mode)
      begin
         if (s_q.s2[5])
            s_d.track = 1'b1; // see RL6
         else if (s_q.s2[6])
            s_d.track = 1'b0; // see RL6
         filter_acq = !s_d.track; // see RL5
      end
      else
      begin
         filter_acq = s_q.ctl[clk_ctrl_pkg::ctl_acq]; // see RL9
         s_d.track = !filter_acq; // see RL4
      end
      if (filter_acq)
         s_d.track = 1'b0; // see RL3
      if (s_q.ctl[clk_ctrl_pkg::ctl_lock_ie] && (lock_next != s_q.lock))
         s_d.lock_irq = 1'b1; // see RL8
      if (bus.ref_tick)
         s_d.ref_ticks = s_q.ref_ticks + 4'h1;
      // Clock monitor: missing oscillator edges for the RC delay.
      if (!s_q.ctl[clk_ctrl_pkg::ctl_cm_en] || rise[0])
         s_d.cm_cnt = 8'h00;
      else if (s_q.cm_cnt != clk_ctrl_pkg::cm_delay_cycles)
         s_d.cm_cnt = s_q.cm_cnt + 8'h01;
      if (s_d.cm_cnt == clk_ctrl_pkg::cm_delay_cycles && s_q.cm_cnt != s_d.cm_cnt && !s_q.scm)
      begin
         s_d.cm_fail = 1'b1; // see RL19
         s_d.cm_event = 1'b1;
         if (s_q.ctl[clk_ctrl_pkg::ctl_scm_en])
         begin
            s_d.scm = 1'b1; // see RL16
            s_d.ctl[clk_ctrl_pkg::ctl_pll_sel] = 1'b0; // see RL23
         end
         else
            s_d.cm_reset = 1'b1; // see RL19
      end
      if (bus.osc_ok && s_q.scm)
      begin
         s_d.scm = 1'b0; // see RL24
         s_d.ctl[clk_ctrl_pkg::ctl_pll_sel] = 1'b0; // see RL24
      end
      // APB writes; a set from hardware in this cycle beats a clear.
      if (wr && hit(paddr, clk_ctrl_pkg::off_divider))
      begin
         s_d.ref_div = pwdata[clk_ctrl_pkg::ref_div_lsb +: clk_ctrl_pkg::ref_div_w];
         s_d.mult = pwdata[clk_ctrl_pkg::mult_lsb +: clk_ctrl_pkg::mult_w];
      end
      if (wr && hit(paddr, clk_ctrl_pkg::off_control))
      begin
         s_d.ctl = pwdata[6:0];
         if (s_d.scm)
            s_d.ctl[clk_ctrl_pkg::ctl_pll_sel] = 1'b0; // see RL23
         if (s_q.ctl[clk_ctrl_pkg::ctl_pll_sel])
            s_d.ctl[clk_ctrl_pkg::ctl_pll_on] = 1'b1; // see RL14
      end
      if (wr && hit(paddr, clk_ctrl_pkg::off_status))
      begin
         if (pwdata[clk_ctrl_pkg::st_lock_irq] && !(s_d.lock_irq && !s_q.lock_irq))
            s_d.lock_irq = 1'b0;
         if (pwdata[clk_ctrl_pkg::st_cm_fail] && !(s_d.cm_fail && !s_q.cm_fail))
            s_d.cm_fail = 1'b0;
      end
      // Glitch-free switch: freeze, count, then swap the source.
      case (s_q.sw)
         clk_ctrl_pkg::sw_idle:
         begin
            if (s_d.ctl[clk_ctrl_pkg::ctl_pll_sel] != s_q.sel_active)
            begin
               s_d.sw = clk_ctrl_pkg::sw_freeze;
               s_d.sw_cnt = 4'h0;
            end
         end
         clk_ctrl_pkg::sw_freeze:
         begin
            s_d.sw_cnt = s_q.sw_cnt + 4'h1;
            if (s_q.sw_cnt == clk_ctrl_pkg::switch_len - 4'h2)
               s_d.sw = clk_ctrl_pkg::sw_swap; // see RL15
         end
         clk_ctrl_pkg::sw_swap:
         begin
            s_d.sel_active = s_q.ctl[clk_ctrl_pkg::ctl_pll_sel]; // see RL13
            s_d.sw = clk_ctrl_pkg::sw_idle;
         end
         default:
            s_d.sw = clk_ctrl_pkg::sw_idle;
      endcase
      s_d.bus_div = (s_q.scm ? rise[1] : rise[0]) ? !s_q.bus_div : s_q.bus_div; // see RL16
      s_d.rdata = 32'h0000_0000;
      if (rd)
      begin
         if (hit(paddr, clk_ctrl_pkg::off_divider))
            s_d.rdata = {18'h00000, s_q.mult, 4'h0, s_q.ref_div};
         else if (hit(paddr, clk_ctrl_pkg::off_control))
            s_d.rdata = {25'h0000000, s_q.ctl};
         else if (hit(paddr, clk_ctrl_pkg::off_status))
            s_d.rdata = {23'h000000, s_q.cm_fail, s_q.sw != clk_ctrl_pkg::sw_idle,
                         s_q.ext_mode, bus.osc_ok, bus.check_busy, s_q.scm,
                         s_q.lock_irq, s_q.track, s_q.lock};
         else if (hit(paddr, clk_ctrl_pkg::off_freq_meas))
            s_d.rdata = {28'h0000000, s_q.ref_ticks};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
         s_q.ctl <= clk_ctrl_pkg::control_reset;
      end
      else
         s_q <= s_d;
   end

   assign prdata = s_q.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(hit(paddr, clk_ctrl_pkg::off_divider)
                    || hit(paddr, clk_ctrl_pkg::off_control)
                    || hit(paddr, clk_ctrl_pkg::off_status)
                    || hit(paddr, clk_ctrl_pkg::off_freq_meas));
   assign main_system_clock_from_pll = s_q.sel_active && !s_q.scm; // see RL13
   assign clocks_frozen = (s_q.sw != clk_ctrl_pkg::sw_idle); // see RL15
   assign self_clock_mode = s_q.scm;
   assign external_clock_mode = s_q.ext_mode;
   assign filter_acquisition = !s_q.track;
   // The checker needs a running VCO even when software has the PLL off.
   assign pll_enable = s_q.ctl[clk_ctrl_pkg::ctl_pll_on] || bus.check_busy || s_q.scm; // see RL22
   assign voltage_regulator_enable = 1'b1 || bus.check_busy; // see RL22
   assign bus_clock_output_pin = s_q.bus_div && !clocks_frozen; // see RL17
   assign lock_irq = s_q.lock_irq;
   assign clock_monitor_reset = s_q.cm_reset;
   assign ref_tick_count = s_q.ref_ticks;
   assign ref_clock_tick = bus.ref_tick;
   assign fb_clock_tick = bus.fb_tick;
endmodule

// ===== verification/clock_controller_asserts.sv
// Port-level checks of the clock controller, attached by bind.
// Assumes pclk and the active-low presetn of the design top.
module clock_controller_asserts
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Watched outputs
   input wire logic main_system_clock_from_pll,
   input wire logic clocks_frozen,
   input wire logic self_clock_mode,
   input wire logic external_clock_mode,
   input wire logic pll_enable,
   input wire logic voltage_regulator_enable,
   input wire logic bus_clock_output_pin,
   input wire logic clock_monitor_reset,
   input wire logic ref_clock_tick,
   input wire logic fb_clock_tick
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_freeze_ends: assert property (
      $rose(clocks_frozen) |-> ##[1:9] !clocks_frozen) else $error("Freeze too long.");
   a_source_moves: assert property (
      $changed(main_system_clock_from_pll) |->
      $past(clocks_frozen) || $past(clocks_frozen, 2) || self_clock_mode)
      else $error("Source changed outside a freeze.");
   a_pll_kept: assert property (
      main_system_clock_from_pll |-> pll_enable) else $error("PLL off while selected.");
   a_scm_power: assert property (
      self_clock_mode && $past(self_clock_mode, 2) |-> pll_enable && voltage_regulator_enable)
      else $error("PLL or regulator off in self clock mode.");
   a_scm_drops_pll: assert property (
      $rose(self_clock_mode) |-> ##[0:12] !main_system_clock_from_pll)
      else $error("PLL still selected in self clock mode.");
   a_cm_pulse: assert property (
      clock_monitor_reset |-> !self_clock_mode ##1 !clock_monitor_reset)
      else $error("Bad monitor reset pulse.");
   a_ref_spacing: assert property (
      ref_clock_tick |=> !ref_clock_tick [*2]) else $error("Reference ticks too close.");
   a_fb_spacing: assert property (
      fb_clock_tick |=> !fb_clock_tick [*3]) else $error("Feedback ticks too close.");
   a_bus_clock_output_pin_hold: assert property (
      clocks_frozen && $past(clocks_frozen) |-> $stable(bus_clock_output_pin))
      else $error("Bus clock pin moved while frozen.");
   a_ext_latched: assert property (
      $past(presetn, 4) |-> $stable(external_clock_mode)) else $error("Clock mode moved.");
endmodule

// ===== verification/osc_source_model.sv
// Oscillator, VCO and frequency detector model on the far side of the controller.
// Assumes the bench sets run and err; err 0 is near target, 1 between, 2 far.
module osc_source_model
(
   // Bench control
   input  wire logic       run,
   input  wire logic [1:0] err,
   // Clocks and detector levels
   output logic            oscillator_clock,
   output logic            pll_output_clock,
   output logic            lock_in_window,
   output logic            lock_out_window,
   output logic            track_in_window,
   output logic            track_out_window
);
   timeunit 1ns;
   timeprecision 100ps;
   // A failed crystal stops at its last level; the monitor must catch exactly that.
   initial
   begin
      oscillator_clock = 1'b0;
      #3;
      forever #20 if (run) oscillator_clock = !oscillator_clock;
   end
   initial
   begin
      pll_output_clock = 1'b0;
      #7;
      forever #30 pll_output_clock = !pll_output_clock;
   end
   // The clear tolerance is wider than the set one, so the middle band holds both flags.
   assign lock_in_window   = (err == 2'h0);
   assign lock_out_window  = (err == 2'h2);
   assign track_in_window  = (err == 2'h0);
   assign track_out_window = (err == 2'h2);
endmodule

// ===== verification/test_pll_clock_select_monitor.sv
// Self-checking bench for the clock controller: APB master, scenarios and verdict.
// Assumes the oscillator model and the checker module are compiled before it.
module test_pll_clock_select_monitor;
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        external_clock_select_pin = 1'b1;
   logic        full_stop_wake = 1'b0;
   logic        run = 1'b1;
   logic [1:0]  err = 2'h2;
   logic [31:0] prdata, rdat;
   logic        pready, pslverr, rerr, oscillator_clock, pll_output_clock;
   logic        lock_in_window, lock_out_window, track_in_window, track_out_window;
   logic        main_system_clock_from_pll, clocks_frozen, self_clock_mode;
   logic        external_clock_mode, filter_acquisition, pll_enable, voltage_regulator_enable;
   logic        bus_clock_output_pin, lock_irq, clock_monitor_reset, ref_clock_tick, fb_clock_tick;
   logic [3:0]  ref_tick_count;
   int          error_cnt = 0;
   int          checked = 0;
   wire logic [8:0] obs = {pready, lock_irq, filter_acquisition, clock_monitor_reset,
      fb_clock_tick, ref_clock_tick, self_clock_mode, clocks_frozen, main_system_clock_from_pll};
   osc_source_model i_osc (.run, .err, .oscillator_clock, .pll_output_clock, .lock_in_window,
      .lock_out_window, .track_in_window, .track_out_window);
   clock_controller i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .oscillator_clock, .pll_output_clock, .external_clock_select_pin,
      .lock_in_window, .lock_out_window, .track_in_window, .track_out_window, .full_stop_wake,
      .main_system_clock_from_pll, .clocks_frozen, .self_clock_mode, .external_clock_mode,
      .filter_acquisition, .pll_enable, .voltage_regulator_enable, .bus_clock_output_pin,
      .lock_irq, .clock_monitor_reset, .ref_tick_count, .ref_clock_tick, .fb_clock_tick);
   always #5 pclk = ~pclk;
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Outputs are looked at on the falling edge, where they have settled.
   task automatic wait_bit(input int i, input logic v, input int lim);
      int n;
      for (n = 0; n < lim; n++)
      begin
         @(negedge pclk);
         if (obs[i] === v)
            break;
      end
      if (n == lim)
      begin
         error_cnt++;
         wrap_up();
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (n == 50)
      begin
         error_cnt++;
         wrap_up();
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   task automatic gap(input int i, input int exp);
      int n;
      wait_bit(i, 1'b1, 3000);
      wait_bit(i, 1'b1, 3000);
      for (n = 1; n < 3000; n++)
      begin
         @(negedge pclk);
         if (obs[i] === 1'b1)
            break;
      end
      chk(n, exp);
      if (i == 3)
      begin
         rdat = 32'(ref_tick_count);
         @(negedge pclk);
         chk(32'(ref_tick_count), (rdat + 32'h1) & 32'hf);
      end
   endtask
   task automatic t_reset;
      apb(1'b0, 12'h004, 32'h0);
      external_clock_select_pin <= 1'b0;
      chk(rdat, 32'(clk_ctrl_pkg::control_reset));
      apb(1'b0, 12'h000, 32'h0);
      chk(rdat, clk_ctrl_pkg::divider_reset);
      apb(1'b0, 12'h008, 32'h0);
      chk(rdat & 32'h50, 32'h50);
      chk(32'(pll_enable), 32'h1);
      chk(32'(external_clock_mode), 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk({rdat[30:0], rerr}, 32'h1);
      $display("Reset test done");
   endtask
   task automatic t_div;
      logic [3:0] r;
      logic [5:0] m;
      for (int k = 0; k < 4; k++)
      begin
         r = k[0] ? 4'hf : 4'h0;
         m = k[1] ? 6'h3f : 6'h00;
         apb(1'b1, 12'h000, {18'h0, m, 4'h0, r});
         gap(3, 4 * (r + 1));
         gap(4, 6 * (2 * m + 2));
      end
      $display("Divider test done");
   endtask
   task automatic t_lock;
      apb(1'b1, 12'h004, 32'h77);
      err <= 2'h0;
      wait_bit(6, 1'b0, 100);
      wait_bit(7, 1'b1, 100);
      apb(1'b0, 12'h008, 32'h0);
      chk(rdat & 32'h7, 32'h7);
      err <= 2'h1;
      repeat (30) @(posedge pclk);
      apb(1'b1, 12'h008, 32'h4);
      apb(1'b0, 12'h008, 32'h0);
      chk(rdat & 32'h7, 32'h3);
      err <= 2'h2;
      wait_bit(6, 1'b1, 100);
      wait_bit(7, 1'b1, 100);
      apb(1'b0, 12'h008, 32'h0);
      chk(rdat & 32'h7, 32'h4);
      apb(1'b1, 12'h008, 32'h4);
      $display("Lock test done");
   endtask
   task automatic t_manual;
      int n;
      err <= 2'h0;
      apb(1'b1, 12'h004, 32'h62);
      apb(1'b1, 12'h004, 32'h66);
      repeat (50) @(posedge pclk);
      apb(1'b0, 12'h008, 32'h0);
      chk(rdat & 32'h3, 32'h1);
      chk(32'(filter_acquisition), 32'h1);
      apb(1'b1, 12'h004, 32'h64);
      wait_bit(6, 1'b0, 10);
      repeat (50) @(posedge pclk);
      apb(1'b1, 12'h004, 32'h6c);
      wait_bit(1, 1'b1, 20);
      for (n = 0; n < 20 && obs[1] === 1'b1; n++)
         @(negedge pclk);
      chk(n, 8);
      wait_bit(0, 1'b1, 4);
      apb(1'b1, 12'h004, 32'h68);
      apb(1'b0, 12'h004, 32'h0);
      chk(rdat & 32'h4, 32'h4);
      $display("Manual and switch test done");
   endtask
   task automatic t_scm;
      run <= 1'b0;
      wait_bit(2, 1'b1, 300);
      wait_bit(0, 1'b0, 20);
      apb(1'b0, 12'h008, 32'h0);
      chk(rdat & 32'h118, 32'h118);
      chk(32'(pll_enable), 32'h1);
      run <= 1'b1;
      $display("Self clock test done");
   endtask
   task automatic t_off;
      int n;
      apb(1'b1, 12'h004, 32'h1);
      chk(32'(external_clock_mode), 32'h0);
      run <= 1'b0;
      n = 0;
      repeat (300)
      begin
         @(negedge pclk);
         if ((self_clock_mode | clock_monitor_reset) !== 1'b0)
            n++;
      end
      chk(n, 0);
      apb(1'b1, 12'h004, 32'h21);
      wait_bit(5, 1'b1, 300);
      chk(32'(self_clock_mode), 32'h0);
      run <= 1'b1;
      $display("Monitor reset test done");
   endtask
   initial
   begin
      do_reset();
      t_reset();
      t_div();
      t_lock();
      t_manual();
      t_scm();
      do_reset();
      t_off();
      wrap_up();
   end
endmodule
bind clock_controller clock_controller_asserts i_chk (.pclk, .presetn,
   .main_system_clock_from_pll, .clocks_frozen, .self_clock_mode, .external_clock_mode,
   .pll_enable, .voltage_regulator_enable, .bus_clock_output_pin, .clock_monitor_reset,
   .ref_clock_tick, .fb_clock_tick);
